/* File: sdram_params.svh */
// Timing counts, command codes, mode fields and register offsets for the SDRAM link.
// Assumes a 125 MHz controller clock shared by both ends.
`ifndef SDRAM_PARAMS_SVH
`define SDRAM_PARAMS_SVH

`define CLK_PERIOD_PS 8000
`define T_RRD_PS 16000
`define T_RCD_PS 19000
`define T_RP_PS 19000
`define T_RAS_PS 48000
`define T_RC_PS 68000
`define T_CK_CL3_MIN_PS 8000
`define T_CK_CL2_MIN_PS 9500
`define T_CK_MAX_PS 1000000
`define T_REFRESH_MS 64
`define REFRESH_ROWS 4096
// Round up to whole clocks
`define CEIL_CYC(t) (((t) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_RRD `CEIL_CYC(`T_RRD_PS)
`define CYC_RCD `CEIL_CYC(`T_RCD_PS)
`define CYC_RP `CEIL_CYC(`T_RP_PS)
`define CYC_RAS `CEIL_CYC(`T_RAS_PS)
`define CYC_RC `CEIL_CYC(`T_RC_PS)
// One clock only below 100 MHz with explicit precharge
`define CYC_WRITE_RECOVERY_GAP ((`CLK_PERIOD_PS > 10000) ? 1 : 2)
`define CYC_WRITE_TO_COLUMN_GAP 1
`define CYC_MRS_GAP 2
// Scaled before the product so the value stays inside 32 bits
`define CYC_REFI (`T_REFRESH_MS * (1000000000 / `REFRESH_ROWS) / `CLK_PERIOD_PS)

// Command codes as {cs_n, ras_n, cas_n, we_n}
`define CMD_MRS 4'h0
`define CMD_REF 4'h1
`define CMD_PRE 4'h2
`define CMD_ACT 4'h3
`define CMD_WR 4'h4
`define CMD_RD 4'h5
`define CMD_BST 4'h6
`define CMD_NOP 4'h7
`define CMD_DESEL 4'hf

`define AP_BIT 10
`define MR_BL_LSB 0
`define MR_CL_LSB 4

`define OFF_CTRL 8'h00
`define OFF_MODE 8'h04
`define OFF_ADDR 8'h08
`define OFF_WDATA 8'h0c
`define OFF_CMD 8'h10
`define OFF_STATUS 8'h14
`define OFF_RDATA 8'h18
`endif

/* File: sdram_pkg.sv */
// Types shared by the controller and the memory end.
// Assumes sdram_params.svh for all numeric constants.
package sdram_pkg;
  typedef logic [7:0] apb_addr_t;
  typedef logic [31:0] word_t;
  typedef logic [3:0] cmd_t;
  typedef enum logic [3:0] {
    ST_BOOT, ST_MRS, ST_IDLE, ST_SELF, ST_COL, ST_PRE, ST_WAIT
  } ctl_state_t;
endpackage

/* File: sdram_link_if.sv */
// Pin-level link between the SDRAM controller and the memory.
// Resolves the shared data bus from the per-end output enables.
interface sdram_link_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] bank_bits;
  logic [11:0] addr;
  logic [3:0] dqm;
  logic [31:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic [31:0] mem_dq_o;
  logic [3:0] mem_dq_oe;
  wire [31:0] dq;

  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign dq[8*i+:8] = mem_dq_oe[i] ? mem_dq_o[8*i+:8] :
                        (ctl_dq_oe ? ctl_dq_o[8*i+:8] : 8'h00);
  end

  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, bank_bits, addr, dqm,
               output ctl_dq_o, ctl_dq_oe, input dq);
  modport mem (input cke, cs_n, ras_n, cas_n, we_n, bank_bits, addr, dqm,
               output mem_dq_o, mem_dq_oe, input dq);
endinterface

/* File: sdram_mem_end.sv */
// Memory end: command decode, banks, mode register, bursts and data pins.
// Assumes the controller drives the link on the same clock edge grid.
`include "sdram_params.svh"
module sdram_mem_end #(
  parameter int ROW_KEEP = 2
) (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  sdram_link_if.mem LINK,
  output logic SELF_REFRESH_O,
  output logic POWER_DOWN_O,
  output logic [3:0] BANK_OPEN_O
);
  import sdram_pkg::*;
  localparam int AW = 2 + ROW_KEEP + 9;

  logic [31:0] store_q [0:(1<<AW)-1];
  logic cke_prev_q;
  logic [13:0] mode_q;
  logic [11:0] row_q [4];
  logic burst_q, bwr_q, bap_q;
  logic [1:0] bbank_q;
  logic [8:0] bcol_q, bleft_q;
  logic [31:0] pipe0_q, pipe1_q, dq_o_q;
  logic pv0_q, pv1_q, ov_q;
  logic [3:0] dqm_q, oe_q;

  // Command pins count only when clock enable was high the edge before
  wire live = cke_prev_q;
  wire cmd_t cmd = LINK.cs_n ? `CMD_DESEL : {1'b0, LINK.ras_n, LINK.cas_n, LINK.we_n};
  wire is_col = live && (cmd == `CMD_RD || cmd == `CMD_WR);
  wire is_pre = live && cmd == `CMD_PRE;
  wire is_bst = live && cmd == `CMD_BST;
  wire is_act = live && cmd == `CMD_ACT;
  wire is_mrs = live && cmd == `CMD_MRS;
  wire self_in = live && !LINK.cke && cmd == `CMD_REF;
  wire [2:0] bl = mode_q[`MR_BL_LSB+:3];
  wire [2:0] cl = mode_q[`MR_CL_LSB+:3];
  // Burst length 1, 2, 4, 8 or full page
  wire [8:0] bmask = bl == 3'h0 ? 9'h000 : bl == 3'h1 ? 9'h001 : bl == 3'h2 ? 9'h003 :
                     bl == 3'h3 ? 9'h007 : bl == 3'h7 ? 9'h1ff : 9'h000;
  // Bank index is the two bank bits as a number
  wire [1:0] cur_bank = is_col ? LINK.bank_bits : bbank_q;
  wire [8:0] cur_col = is_col ? LINK.addr[8:0] : bcol_q;
  wire cur_wr = is_col ? !LINK.we_n : bwr_q;
  wire stop = is_bst || (is_pre && (LINK.addr[`AP_BIT] || LINK.bank_bits == bbank_q));
  // Precharge of the burst bank or of all banks, burst stop or a new column command cuts the burst
  wire cur_on = is_col || (burst_q && live && !stop);
  wire [11:0] cur_row = row_q[cur_bank];
  wire [AW-1:0] cur_a = {cur_bank, cur_row[ROW_KEEP-1:0], cur_col};
  wire [31:0] rd_word = store_q[cur_a];
  wire [8:0] nxt_col = (cur_col & ~bmask) | ((cur_col + 9'h001) & bmask);
  wire [8:0] left = is_col ? bmask : bleft_q;
  wire last = left == 9'h000;
  wire ap_now = is_col ? LINK.addr[`AP_BIT] : bap_q;
  wire new_rd = cur_on && !cur_wr;

  // Byte masks block write data on the same edge
  always_ff @(posedge MCLK_I) begin
    for (int i = 0; i < 4; i++) begin
      if (cur_on && cur_wr && !LINK.dqm[i]) begin
        store_q[cur_a][8*i+:8] <= LINK.dq[8*i+:8];
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cke_prev_q <= 1'b0;
      mode_q <= 14'h0000;
      BANK_OPEN_O <= 4'h0;
      SELF_REFRESH_O <= 1'b0;
      POWER_DOWN_O <= 1'b0;
      burst_q <= 1'b0;
      bwr_q <= 1'b0;
      bap_q <= 1'b0;
      bbank_q <= 2'h0;
      bcol_q <= 9'h000;
      bleft_q <= 9'h000;
      for (int b = 0; b < 4; b++) begin
        row_q[b] <= 12'h000;
      end
    end else begin
      cke_prev_q <= LINK.cke;
      POWER_DOWN_O <= !LINK.cke;
      if (self_in) begin
        SELF_REFRESH_O <= 1'b1;
      end else if (SELF_REFRESH_O && LINK.cke) begin
        SELF_REFRESH_O <= 1'b0;
      end
      if (is_mrs) begin
        mode_q <= {LINK.bank_bits, LINK.addr};
      end
      if (is_act) begin
        row_q[LINK.bank_bits] <= LINK.addr;
        BANK_OPEN_O[LINK.bank_bits] <= 1'b1;
      end
      if (is_pre && LINK.addr[`AP_BIT]) begin
        BANK_OPEN_O <= 4'h0;
      end else if (is_pre) begin
        BANK_OPEN_O[LINK.bank_bits] <= 1'b0;
      end else if (cur_on && last && ap_now) begin
        BANK_OPEN_O[cur_bank] <= 1'b0;
      end
      if (is_col || !live || stop) begin
        burst_q <= is_col ? !last : (burst_q && !stop);
      end else if (burst_q) begin
        burst_q <= !last;
      end
      if (cur_on) begin
        bbank_q <= cur_bank;
        bcol_q <= nxt_col;
        bwr_q <= cur_wr;
        bap_q <= ap_now;
        bleft_q <= (bl == 3'h7) ? left : left - 9'h001;
      end
    end
  end

  // Read latency pipeline; frozen while clock is suspended
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pipe0_q <= 32'h0;
      pipe1_q <= 32'h0;
      pv0_q <= 1'b0;
      pv1_q <= 1'b0;
      ov_q <= 1'b0;
      dq_o_q <= 32'h0;
      dqm_q <= 4'h0;
      oe_q <= 4'h0;
    end else if (live) begin
      dqm_q <= LINK.dqm;
      pipe1_q <= rd_word;
      pv1_q <= new_rd;
      pipe0_q <= (cl == 3'h3) ? pipe1_q : rd_word;
      pv0_q <= (cl == 3'h3) ? pv1_q : new_rd;
      dq_o_q <= (cl == 3'h1) ? rd_word : pipe0_q;
      ov_q <= (cl == 3'h1) ? new_rd : pv0_q;
      // Masked read bytes float two clocks after the mask edge
      oe_q <= {4{(cl == 3'h1) ? new_rd : pv0_q}} & ~dqm_q;
    end
  end

  assign LINK.mem_dq_o = dq_o_q;
  assign LINK.mem_dq_oe = oe_q;
endmodule

/* File: sdram_ctl_end.sv */
// Controller end: APB register file, init, refresh and closed-page single accesses.
// Assumes an APB master on MCLK_I and the memory on the same clock.
//
// The register addresses and register access over APB were decided locally.
`include "sdram_params.svh"
module sdram_ctl_end #(
  parameter int REFI_CYC = `CYC_REFI
) (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire sdram_pkg::apb_addr_t PADDR_I,
  input wire sdram_pkg::word_t PWDATA_I,
  output sdram_pkg::word_t PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  sdram_link_if.ctl LINK
);
  import sdram_pkg::*;

  ctl_state_t state_q, ret_q;
  logic [1:0] ctrl_q;
  logic [13:0] mode_q;
  logic [25:0] addr_q;
  word_t wdata_q, rdata_q;
  logic go_q, gowr_q, rvalid_q, init_q;
  logic [3:0] gomask_q;
  logic [7:0] wait_q, ras_q, rc_q;
  logic [2:0] cap_q;
  logic [15:0] refi_q;
  logic ref_pend_q;
  cmd_t cmd_q;
  logic cke_q, dq_oe_q;
  logic [1:0] ba_q;
  logic [11:0] a_q;
  logic [3:0] dqm_q;
  word_t dq_q;

  // APB decode
  wire setup = PSEL_I && !PENABLE_I;
  wire acc = PSEL_I && PENABLE_I && PREADY_O;
  wire wr_acc = acc && PWRITE_I;
  wire hit_ctrl = PADDR_I == `OFF_CTRL;
  wire hit_mode = PADDR_I == `OFF_MODE;
  wire hit_addr = PADDR_I == `OFF_ADDR;
  wire hit_wdata = PADDR_I == `OFF_WDATA;
  wire hit_cmd = PADDR_I == `OFF_CMD;
  wire hit_status = PADDR_I == `OFF_STATUS;
  wire hit_rdata = PADDR_I == `OFF_RDATA;
  wire mapped = hit_ctrl || hit_mode || hit_addr || hit_wdata || hit_cmd || hit_status ||
                hit_rdata;
  wire [2:0] cl = mode_q[`MR_CL_LSB+:3];
  // Latency three needs 8 ns, two needs 9.5 ns, one is not offered here
  wire cfg_err = (cl == 3'h3) ? (`CLK_PERIOD_PS < `T_CK_CL3_MIN_PS) :
                 (cl == 3'h2) ? (`CLK_PERIOD_PS < `T_CK_CL2_MIN_PS) : 1'b1;
  wire per_err = `CLK_PERIOD_PS > `T_CK_MAX_PS;
  wire busy = (state_q != ST_IDLE) || go_q;
  wire self_on = state_q == ST_SELF;
  word_t status;
  assign status = {27'h0, cfg_err || per_err, self_on, rvalid_q, init_q, busy};
  word_t rd_mux;
  assign rd_mux = hit_ctrl ? {30'h0, ctrl_q} : hit_mode ? {18'h0, mode_q} :
                  hit_addr ? {6'h0, addr_q} : hit_wdata ? wdata_q :
                  hit_cmd ? {24'h0, gomask_q, 3'h0, gowr_q} : hit_status ? status :
                  hit_rdata ? rdata_q : 32'h0;
  wire go_set = wr_acc && hit_cmd;
  wire rd_clear = acc && !PWRITE_I && hit_rdata;
  wire idle_free = state_q == ST_IDLE && rc_q == 8'h00;
  wire ref_take = idle_free && ref_pend_q;
  wire self_take = idle_free && !ref_pend_q && ctrl_q[1];
  wire go_take = idle_free && !ref_pend_q && !ctrl_q[1] && go_q && init_q;
  wire cap_hit = cap_q == 3'h1;
  wire refi_tick = refi_q == 16'h0000;

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0;
    end else begin
      PREADY_O <= setup;
      PSLVERR_O <= setup && !mapped;
      if (setup && !PWRITE_I) begin
        PRDATA_O <= rd_mux;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctrl_q <= 2'h0;
      mode_q <= 14'h0030;
      addr_q <= 26'h0;
      wdata_q <= 32'h0;
      gowr_q <= 1'b0;
      gomask_q <= 4'h0;
    end else if (wr_acc) begin
      if (hit_ctrl) ctrl_q <= PWDATA_I[1:0];
      if (hit_mode) mode_q <= PWDATA_I[13:0];
      if (hit_addr) addr_q <= PWDATA_I[25:0];
      if (hit_wdata) wdata_q <= PWDATA_I;
      if (hit_cmd) begin
        gowr_q <= PWDATA_I[0];
        gomask_q <= PWDATA_I[7:4];
      end
    end
  end

  // Pending flags: a set in the clearing cycle wins
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      go_q <= 1'b0;
      rvalid_q <= 1'b0;
      ref_pend_q <= 1'b0;
      refi_q <= 16'h0;
      cap_q <= 3'h0;
      rdata_q <= 32'h0;
    end else begin
      go_q <= go_set || (go_q && !go_take);
      rvalid_q <= cap_hit || (rvalid_q && !rd_clear);
      ref_pend_q <= (refi_tick && init_q) || (ref_pend_q && !ref_take);
      refi_q <= refi_tick ? 16'(REFI_CYC - 1) : refi_q - 16'h0001;
      if (cap_hit) begin
        rdata_q <= LINK.dq;
      end
      if (state_q == ST_COL && !gowr_q) begin
        cap_q <= 3'(cl + 3'h1);
      end else if (cap_q != 3'h0) begin
        cap_q <= cap_q - 3'h1;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_q <= ST_BOOT;
      ret_q <= ST_BOOT;
      init_q <= 1'b0;
      wait_q <= 8'h00;
      ras_q <= 8'h00;
      rc_q <= 8'h00;
      cmd_q <= `CMD_DESEL;
      cke_q <= 1'b1;
      ba_q <= 2'h0;
      a_q <= 12'h000;
      dqm_q <= 4'h0;
      dq_q <= 32'h0;
      dq_oe_q <= 1'b0;
    end else begin
      cmd_q <= `CMD_NOP;
      dq_oe_q <= 1'b0;
      dqm_q <= 4'h0;
      if (ras_q != 8'h00) ras_q <= ras_q - 8'h01;
      if (rc_q != 8'h00) rc_q <= rc_q - 8'h01;
      unique case (state_q)
        ST_BOOT: begin
          if (ctrl_q[0]) begin
            cmd_q <= `CMD_PRE;
            a_q[`AP_BIT] <= 1'b1;
            wait_q <= 8'(`CYC_RP - 2);
            ret_q <= ST_MRS;
            state_q <= ST_WAIT;
          end
        end
        ST_MRS: begin
          cmd_q <= `CMD_MRS;
          {ba_q, a_q} <= {mode_q[13:3], 3'h0};
          wait_q <= 8'(`CYC_MRS_GAP - 2);
          ret_q <= ST_IDLE;
          state_q <= ST_WAIT;
          init_q <= 1'b1;
        end
        ST_IDLE: begin
          // Closed-page policy keeps all banks precharged here
          if (ref_take || self_take) begin
            cmd_q <= `CMD_REF;
            cke_q <= !self_take;
            rc_q <= 8'(`CYC_RC - 1);
            if (self_take) state_q <= ST_SELF;
          end else if (go_take) begin
            cmd_q <= `CMD_ACT;
            ba_q <= addr_q[25:24];
            a_q <= addr_q[23:12];
            ras_q <= 8'(`CYC_RAS - 1);
            rc_q <= 8'(`CYC_RC - 1);
            wait_q <= 8'(`CYC_RCD - 2);
            ret_q <= ST_COL;
            state_q <= ST_WAIT;
          end
        end
        ST_SELF: begin
          cke_q <= 1'b0;
          if (!ctrl_q[1]) begin
            cke_q <= 1'b1;
            rc_q <= 8'(`CYC_RC - 1);
            state_q <= ST_IDLE;
          end
        end
        ST_COL: begin
          cmd_q <= gowr_q ? `CMD_WR : `CMD_RD;
          a_q <= {3'h0, addr_q[8:0]};
          if (gowr_q) begin
            dq_q <= wdata_q;
            dq_oe_q <= 1'b1;
            dqm_q <= gomask_q;
            wait_q <= 8'(`CYC_WRITE_RECOVERY_GAP - 1);
          end else begin
            wait_q <= 8'h00;
          end
          ret_q <= ST_PRE;
          state_q <= ST_WAIT;
        end
        ST_PRE: begin
          if (ras_q == 8'h00) begin
            cmd_q <= `CMD_PRE;
            a_q[`AP_BIT] <= 1'b0;
            wait_q <= 8'(`CYC_RP - 2);
            ret_q <= ST_IDLE;
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (wait_q == 8'h00) begin
            state_q <= ret_q;
          end else begin
            wait_q <= wait_q - 8'h01;
          end
        end
      endcase
    end
  end

  assign LINK.cke = cke_q;
  assign {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} = cmd_q;
  assign LINK.bank_bits = ba_q;
  assign LINK.addr = a_q;
  assign LINK.dqm = dqm_q;
  assign LINK.ctl_dq_o = dq_q;
  assign LINK.ctl_dq_oe = dq_oe_q;
endmodule

/* File: sdram_link_props.sv */
// Checker: command spacing and pin relations on the controller-memory link.
// Assumes the command codes of sdram_params.svh and one shared clock.
`include "sdram_params.svh"
module sdram_link_props (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [11:0] addr,
  input wire logic ctl_dq_oe,
  input wire logic [3:0] mem_dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire act = cke && cmd == `CMD_ACT;
  wire pre = cke && cmd == `CMD_PRE;
  wire wr = cke && cmd == `CMD_WR;
  wire rd = cke && cmd == `CMD_RD;
  wire mode_register_set = cke && cmd == `CMD_MRS;
  wire quiet = cs_n || cmd == `CMD_NOP;
  logic open_q;

  // Tracks whether a row is open
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) open_q <= 1'b0;
    else if (act) open_q <= 1'b1;
    else if (pre) open_q <= 1'b0;
  end

  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);

  property p_act_gap; act |=> !act [*8]; endproperty
  a_act_gap: assert property (p_act_gap) else $error("activate too soon");
  property p_act_col; act |-> ##3 (wr || rd); endproperty
  a_act_col: assert property (p_act_col) else $error("column not 3 after activate");
  property p_act_pre; act |=> !pre [*5]; endproperty
  a_act_pre: assert property (p_act_pre) else $error("precharge too soon");
  property p_pre_act; pre |=> !act [*2]; endproperty
  a_pre_act: assert property (p_pre_act) else $error("activate after precharge");
  property p_wr_pre; wr |=> !pre; endproperty
  a_wr_pre: assert property (p_wr_pre) else $error("write recovery short");
  property p_wr_data; wr |-> ctl_dq_oe && !addr[10] && open_q; endproperty
  a_wr_data: assert property (p_wr_data) else $error("write pins wrong");
  property p_mrs_gap; mode_register_set |-> !open_q ##1 quiet; endproperty
  a_mrs_gap: assert property (p_mrs_gap) else $error("mode set spacing");
  property p_ref_closed; cmd == `CMD_REF |-> !open_q; endproperty
  a_ref_closed: assert property (p_ref_closed) else $error("refresh with row open");
  property p_rd_out; rd |-> ##[1:6] (mem_dq_oe == 4'hf); endproperty
  a_rd_out: assert property (p_rd_out) else $error("read data not driven");
  property p_sr_entry; $fell(cke) |-> cmd == `CMD_REF; endproperty
  a_sr_entry: assert property (p_sr_entry) else $error("bad self refresh entry");
  property p_sr_exit; $rose(cke) |-> quiet [*8]; endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("command after exit");
endmodule

/* File: tb_top.sv */
// Testbench: APB orders into the controller, memory end on the far side.
// Assumes sdram_params.svh offsets and the zero-wait APB slave.
`include "sdram_params.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sdram_pkg::*;
  typedef struct {word_t exp; word_t msk; logic err;} note_t;
  logic MCLK_I = 1'b0;
  logic RST_B_I = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  apb_addr_t paddr = '0;
  word_t pwdata = '0;
  word_t prdata;
  logic pready, pslverr, self_ref, pdown;
  logic [3:0] bank_open;
  int err_total = 0;
  int cmp_count = 0;
  note_t notes[$];
  logic [1:0] e_bank = '0;
  logic [8:0] e_col = '0;
  logic [3:0] e_msk = '0;
  word_t e_dat = '0;

  sdram_link_if sdram_link_if_i ();
  wire [3:0] lcmd = {sdram_link_if_i.cs_n, sdram_link_if_i.ras_n,
                     sdram_link_if_i.cas_n, sdram_link_if_i.we_n};

  always #4 MCLK_I = ~MCLK_I;

  sdram_ctl_end #(.REFI_CYC(200)) sdram_ctl_end_i (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .LINK(sdram_link_if_i));
  sdram_mem_end #(.ROW_KEEP(2)) sdram_mem_end_i (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I),
    .LINK(sdram_link_if_i), .SELF_REFRESH_O(self_ref), .POWER_DOWN_O(pdown),
    .BANK_OPEN_O(bank_open));
  sdram_link_props sdram_link_props_i (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I),
    .cke(sdram_link_if_i.cke), .cs_n(sdram_link_if_i.cs_n), .ras_n(sdram_link_if_i.ras_n),
    .cas_n(sdram_link_if_i.cas_n), .we_n(sdram_link_if_i.we_n), .addr(sdram_link_if_i.addr),
    .ctl_dq_oe(sdram_link_if_i.ctl_dq_oe), .mem_dq_oe(sdram_link_if_i.mem_dq_oe));

  task report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Read results checked against the oldest note
  always @(posedge MCLK_I) begin
    note_t n;
    if (psel && penable && pready && !pwrite && notes.size() > 0) begin
      n = notes.pop_front();
      if (n.msk != 0) begin
        `CHK("prdata", n.exp, prdata & n.msk)
        `CHK("pslverr", n.err, pslverr)
      end
    end
  end

  // Column commands checked on the wire
  always @(posedge MCLK_I) begin
    if (sdram_link_if_i.cke && (lcmd == `CMD_WR || lcmd == `CMD_RD)) begin
      `CHK("bank_bits", e_bank, sdram_link_if_i.bank_bits)
      `CHK("column", e_col, sdram_link_if_i.addr[8:0])
      if (lcmd == `CMD_WR) begin
        `CHK("dqm", e_msk, sdram_link_if_i.dqm)
        `CHK("dq", e_dat, sdram_link_if_i.dq)
      end
    end
  end

  task automatic apb(input logic wr, input apb_addr_t a, input word_t d, output word_t q);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge MCLK_I);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge MCLK_I);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    @(posedge MCLK_I);
  endtask

  task automatic wr(input apb_addr_t a, input word_t d);
    word_t q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input apb_addr_t a, input word_t e, input word_t m, input logic er);
    word_t q;
    notes.push_back(note_t'{e & m, m, er});
    apb(1'b0, a, '0, q);
  endtask

  task automatic wait_bit(input int b, input logic v);
    word_t q;
    int n;
    n = 0;
    do begin
      notes.push_back(note_t'{32'h0, 32'h0, 1'b0});
      apb(1'b0, `OFF_STATUS, '0, q);
      n++;
    end while (q[b] !== v && n < 100);
    if (q[b] !== v) begin
      err_total++;
      report_and_stop();
    end
  endtask

  task automatic access(input logic [1:0] b, input logic [8:0] c, input logic w,
                        input word_t d, input logic [3:0] m);
    e_bank = b;
    e_col = c;
    e_msk = m;
    e_dat = d;
    wr(`OFF_ADDR, {6'h0, b, 10'h0, b, 3'h0, c});
    if (w) wr(`OFF_WDATA, d);
    wr(`OFF_CMD, {24'h0, m, 3'h0, w});
    wait_bit(0, 1'b0);
    `CHK("bank_open", 4'h0, bank_open)
    if (!w) wait_bit(2, 1'b1);
  endtask

  initial begin
    word_t d1, d2, m32;
    logic [3:0] m;
    logic [8:0] c;
    void'($urandom(32'h24b9));
    repeat (16) @(posedge MCLK_I);
    RST_B_I <= 1'b1;
    @(posedge MCLK_I);
    rd(`OFF_MODE, 32'h30, 32'h3fff, 1'b0);
    rd(`OFF_STATUS, 32'h1, 32'h1f, 1'b0);
    rd(8'h1c, 32'h0, 32'hffffffff, 1'b1);
    for (int l = 1; l <= 3; l++) begin
      wr(`OFF_MODE, word_t'(l << 4));
      rd(`OFF_STATUS, (l != 3) ? 32'h10 : 32'h0, 32'h10, 1'b0);
    end
    $display("test registers done");
    wr(`OFF_CTRL, 32'h1);
    wait_bit(1, 1'b1);
    $display("test init done");
    for (int b = 0; b < 4; b++) begin
      d1 = $urandom();
      d2 = $urandom();
      m = 4'($urandom());
      c = 9'($urandom());
      m32 = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
      access(2'(b), c, 1'b1, d1, 4'h0);
      access(2'(b), c, 1'b1, d2, m);
      access(2'(b), c, 1'b0, '0, 4'h0);
      rd(`OFF_RDATA, (d2 & ~m32) | (d1 & m32), 32'hffffffff, 1'b0);
    end
    $display("test banks done");
    wr(`OFF_CTRL, 32'h2);
    wait_bit(3, 1'b1);
    `CHK("self_refresh", 1'b1, self_ref)
    `CHK("cke", 1'b0, sdram_link_if_i.cke)
    `CHK("power_down", 1'b1, pdown)
    wr(`OFF_CTRL, 32'h0);
    wait_bit(3, 1'b0);
    access(2'h3, c, 1'b0, '0, 4'h0);
    rd(`OFF_RDATA, (d2 & ~m32) | (d1 & m32), 32'hffffffff, 1'b0);
    $display("test self refresh done");
    report_and_stop();
  end
endmodule
